// ===== rtl/tbac_defines.vh
// tbac_defines.vh: register map, field positions, reset values and codes
// for the 16-bit timer with byte-wide register access.
// assumes a 32-bit APB bus, one byte register in the low bits of each word.
// Summary of operation
// [RL1] counter, both compares and capture are 16 bits, reached as two bytes
// [RL2] one 8-bit high-byte holding register shared by all 16-bit registers
// [RL3] low-byte write loads held high byte and new low byte at once
// [RL4] low-byte read copies target high byte into holding register same cycle
// [RL5] compare reads return both bytes directly, holding register untouched
// [RL6] software writes high byte first, reads low byte first
// [RL7] main code masks interrupts around two-byte accesses shared with handlers
// [RL8] both control registers are plain 8-bit single-byte registers
// [RL9] four sources in one flag register, each with its own mask bit
// [RL10] counter advances only on the selected tick; stopped with no source
// [RL11] both buffered compare values are compared with the counter every cycle
// [RL12] a compare match sets its match flag, which can request an interrupt
// [RL13] compare results drive PWM or frequency waves on the compare outputs
// [RL14] an edge on capture pin or comparator copies counter into capture unless capture is top
// [RL15] optional noise filter suppresses short spikes before edge detection
// [RL16] counter value 0x0000 is the bottom condition and is signalled
// [RL17] counter value 0xFFFF is the maximum, distinct from top
// [RL18] top is 0xFFFF, 0x00FF, 0x01FF, 0x03FF, compare A or capture per mode
// [RL19] compare A as top in PWM gives no PWM output and stays buffered
// [RL20] power-off bit set keeps the timer disabled; software clears it
// [RL21] a CPU write to the counter wins over count or clear that cycle
// [RL22] writing one clears a flag, writing zero leaves it
// [RL23] high-byte writes only load the holding register
`ifndef TBAC_DEFINES_VH
`define TBAC_DEFINES_VH
// register byte addresses
`define TBAC_A_CTRLA   8'h00
`define TBAC_A_CTRLB   8'h04
`define TBAC_A_CNT_LO  8'h08
`define TBAC_A_CNT_HI  8'h0C
`define TBAC_A_CMPA_LO 8'h10
`define TBAC_A_CMPA_HI 8'h14
`define TBAC_A_CMPB_LO 8'h18
`define TBAC_A_CMPB_HI 8'h1C
`define TBAC_A_CAP_LO  8'h20
`define TBAC_A_CAP_HI  8'h24
`define TBAC_A_FLAG    8'h28
`define TBAC_A_MASK    8'h2C
`define TBAC_A_POWER   8'h30
// field positions
`define TBAC_CA_WGM    1:0
`define TBAC_CA_MODEB  5:4
`define TBAC_CA_MODEA  7:6
`define TBAC_CB_CS     2:0
`define TBAC_CB_WGM    4:3
`define TBAC_CB_SRC    5
`define TBAC_CB_EDGE   6
`define TBAC_CB_FILT   7
`define TBAC_F_OVF     0
`define TBAC_F_MA      1
`define TBAC_F_MB      2
`define TBAC_F_CAP     5
`define TBAC_FLAG_BITS 8'h27
`define TBAC_P_OFF     0
// reset values
`define TBAC_RST_BYTE  8'h00
`define TBAC_RST_WORD  16'h0000
`define TBAC_RST_POWER 8'h00
// counter values
`define TBAC_BOTTOM    16'h0000
`define TBAC_ONE       16'h0001
`define TBAC_MAX       16'hFFFF
`define TBAC_TOP8      16'h00FF
`define TBAC_TOP9      16'h01FF
`define TBAC_TOP10     16'h03FF
// clock select codes
`define TBAC_CS_STOP   3'h0
`define TBAC_CS_DIV1   3'h1
`define TBAC_CS_DIV8   3'h2
`define TBAC_CS_DIV64  3'h3
`define TBAC_CS_DIV256 3'h4
`define TBAC_CS_DIV1K  3'h5
`define TBAC_CS_EXTF   3'h6
`define TBAC_CS_EXTR   3'h7
// compare output modes
`define TBAC_OM_OFF    2'h0
`define TBAC_OM_TOG    2'h1
`define TBAC_OM_CLR    2'h2
`define TBAC_OM_SET    2'h3
`endif

// ===== rtl/tbac_core.v
// tbac_core.v: 16-bit timer/counter with byte-wide access, APB slave.
// assumes one clock sys_clk; pins come from other domains and are synced.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "tbac_defines.vh"
module tbac_core #(
   parameter ADDR_W   = 8,
   parameter FILT_LEN = 4
) (
   input  wire              sys_clk,
   input  wire              resetn,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   input  wire [3:0]        pstrb,
   output reg  [31:0]       prdata,
   output reg               pready,
   output reg               pslverr,
   input  wire              capture_input_pin,
   input  wire              comparator_out,
   input  wire              external_count_pin,
   output reg               wave_out_a,
   output reg               wave_out_b,
   output reg               timer_irq,
   output reg               count_at_bottom,
   output reg               count_at_max
);
   // software-visible state, buffered compares, count direction and prescaler
   reg [7:0]  timer_ctrl_a_q;
   reg [7:0]  timer_ctrl_b_q;
   reg [7:0]  hold_hi_q;
   reg [15:0] count_value_q;
   reg [15:0] compare_a_value_q;
   reg [15:0] compare_b_value_q;
   reg [15:0] cmpa_eff_q;
   reg [15:0] cmpb_eff_q;
   reg [15:0] capture_value_q;
   reg [7:0]  timer_flag_reg_q;
   reg [7:0]  timer_mask_reg_q;
   reg [7:0]  power_q;
   reg        dir_up_q;
   reg [9:0]  pre_q;
   // synchronisers and filters
   reg [1:0]  ext_sync_q;
   reg        ext_prev_q;
   reg [1:0]  icp_sync_q;
   reg [1:0]  aco_sync_q;
   reg [FILT_LEN-1:0] filt_q;
   reg        cap_lvl_q;
   reg        cap_prev_q;

   wire       en = ~power_q[`TBAC_P_OFF]; // RL20
   wire       act = psel & penable & ~pready;
   wire       done = psel & penable & pready;
   wire       wr = done & pwrite & pstrb[0] & en;
   wire [7:0] wb = pwdata[7:0];
   wire [3:0] wgm = {timer_ctrl_b_q[`TBAC_CB_WGM],
                     timer_ctrl_a_q[`TBAC_CA_WGM]};
   wire [2:0] cs = timer_ctrl_b_q[`TBAC_CB_CS];

   // mode decode: top source, slope and buffering
   reg [15:0] top;
   reg        dual;
   reg        pwm;
   reg        a_top;
   reg        cap_top;
   always @* begin
      top     = `TBAC_MAX;
      dual    = 1'b0;
      pwm     = 1'b1;
      a_top   = 1'b0;
      cap_top = 1'b0;
      case (wgm)
         4'h0: pwm = 1'b0;
         4'h1: begin top = `TBAC_TOP8; dual = 1'b1; end // RL18
         4'h2: begin top = `TBAC_TOP9; dual = 1'b1; end // RL18
         4'h3: begin top = `TBAC_TOP10; dual = 1'b1; end // RL18
         4'h4: begin top = compare_a_value_q; pwm = 1'b0; a_top = 1'b1; end
         4'h5: top = `TBAC_TOP8;
         4'h6: top = `TBAC_TOP9;
         4'h7: top = `TBAC_TOP10;
         4'h8: begin top = capture_value_q; dual = 1'b1; cap_top = 1'b1; end
         4'h9: begin top = cmpa_eff_q; dual = 1'b1; a_top = 1'b1; end
         4'hA: begin top = capture_value_q; dual = 1'b1; cap_top = 1'b1; end
         4'hB: begin top = cmpa_eff_q; dual = 1'b1; a_top = 1'b1; end
         4'hC: begin top = capture_value_q; pwm = 1'b0; cap_top = 1'b1; end
         4'hE: begin top = capture_value_q; cap_top = 1'b1; end
         4'hF: begin top = cmpa_eff_q; a_top = 1'b1; end // RL19
         default: pwm = 1'b0;
      endcase
   end

   // tick select; prescaler free runs so taps stay phase-locked
   wire ext_rise = ext_sync_q[1] & ~ext_prev_q;
   wire ext_fall = ~ext_sync_q[1] & ext_prev_q;
   reg  tick;
   always @* begin
      case (cs)
         `TBAC_CS_DIV1:   tick = 1'b1;
         `TBAC_CS_DIV8:   tick = &pre_q[2:0];
         `TBAC_CS_DIV64:  tick = &pre_q[5:0];
         `TBAC_CS_DIV256: tick = &pre_q[7:0];
         `TBAC_CS_DIV1K:  tick = &pre_q[9:0];
         `TBAC_CS_EXTF:   tick = ext_fall;
         `TBAC_CS_EXTR:   tick = ext_rise;
         default:         tick = 1'b0; // RL10
      endcase
   end
   wire run = tick & en; // RL10

   // continuous comparators, no sampling window
   wire at_top = (count_value_q == top);
   wire at_bot = (count_value_q == `TBAC_BOTTOM); // RL16
   wire mat_a  = (count_value_q == cmpa_eff_q); // RL11
   wire mat_b  = (count_value_q == cmpb_eff_q); // RL11
   wire ovf_ev = dual ? (at_bot & ~dir_up_q)
                      : (pwm ? at_top : count_value_q == `TBAC_MAX); // RL17

   // capture source, optional filter, edge detect
   wire cap_raw = timer_ctrl_b_q[`TBAC_CB_SRC] ? aco_sync_q[1]
                                                : icp_sync_q[1];
   wire filt_all1 = &filt_q;
   wire filt_all0 = ~|filt_q;
   wire cap_now = timer_ctrl_b_q[`TBAC_CB_FILT] ? cap_lvl_q : cap_raw;
   wire cap_ev = en & ~cap_top &
                 (timer_ctrl_b_q[`TBAC_CB_EDGE] ? (cap_now & ~cap_prev_q)
                                                : (~cap_now & cap_prev_q));

   // pin synchronisers; second stage alone feeds logic
   always @(posedge sys_clk) begin
      if (!resetn) begin
         ext_sync_q <= 2'h0;
         ext_prev_q <= 1'b0;
         icp_sync_q <= 2'h0;
         aco_sync_q <= 2'h0;
         pre_q      <= 10'h000;
      end else begin
         ext_sync_q <= {ext_sync_q[0], external_count_pin};
         ext_prev_q <= ext_sync_q[1];
         icp_sync_q <= {icp_sync_q[0], capture_input_pin};
         aco_sync_q <= {aco_sync_q[0], comparator_out};
         if (en)
            pre_q <= pre_q + 10'h001;
      end
   end

   // noise filter: level changes only after FILT_LEN equal samples
   always @(posedge sys_clk) begin
      if (!resetn) begin
         filt_q     <= {FILT_LEN{1'b0}};
         cap_lvl_q  <= 1'b0;
         cap_prev_q <= 1'b0;
      end else begin
         filt_q <= {filt_q[FILT_LEN-2:0], cap_raw}; // RL15
         if (filt_all1)
            cap_lvl_q <= 1'b1; // RL15
         else if (filt_all0)
            cap_lvl_q <= 1'b0; // RL15
         cap_prev_q <= cap_now;
      end
   end

   // read mux; unmapped addresses answer with an error
   reg [7:0] rd;
   reg       hit;
   always @* begin
      rd  = 8'h00;
      hit = 1'b1;
      case (paddr)
         `TBAC_A_CTRLA:   rd = timer_ctrl_a_q; // RL8
         `TBAC_A_CTRLB:   rd = timer_ctrl_b_q; // RL8
         `TBAC_A_CNT_LO:  rd = count_value_q[7:0];
         `TBAC_A_CNT_HI:  rd = hold_hi_q;
         `TBAC_A_CMPA_LO: rd = compare_a_value_q[7:0];
         `TBAC_A_CMPA_HI: rd = compare_a_value_q[15:8]; // RL5
         `TBAC_A_CMPB_LO: rd = compare_b_value_q[7:0];
         `TBAC_A_CMPB_HI: rd = compare_b_value_q[15:8]; // RL5
         `TBAC_A_CAP_LO:  rd = capture_value_q[7:0];
         `TBAC_A_CAP_HI:  rd = hold_hi_q;
         `TBAC_A_FLAG:    rd = timer_flag_reg_q; // RL9
         `TBAC_A_MASK:    rd = timer_mask_reg_q; // RL9
         `TBAC_A_POWER:   rd = power_q;
         default:         hit = 1'b0;
      endcase
      if (!en && paddr != `TBAC_A_POWER)
         rd = 8'h00;
   end

   // apb handshake: one wait state, read data sampled in the first access
   always @(posedge sys_clk) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready <= act;
         if (act) begin
            pslverr <= ~hit;
            prdata  <= pwrite ? 32'h00000000 : {24'h000000, rd};
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // holding register: high writes and low reads of count/capture
   wire rd_lo = act & ~pwrite & en;
   always @(posedge sys_clk) begin
      if (!resetn) begin
         hold_hi_q <= `TBAC_RST_BYTE;
      end else if (wr && (paddr == `TBAC_A_CNT_HI ||
                          paddr == `TBAC_A_CMPA_HI ||
                          paddr == `TBAC_A_CMPB_HI ||
                          paddr == `TBAC_A_CAP_HI)) begin
         hold_hi_q <= wb; // RL2 RL23
      end else if (rd_lo && paddr == `TBAC_A_CNT_LO) begin
         hold_hi_q <= count_value_q[15:8]; // RL4
      end else if (rd_lo && paddr == `TBAC_A_CAP_LO) begin
         hold_hi_q <= capture_value_q[15:8]; // RL4
      end
   end

   // control, mask and power registers
   always @(posedge sys_clk) begin
      if (!resetn) begin
         timer_ctrl_a_q   <= `TBAC_RST_BYTE;
         timer_ctrl_b_q   <= `TBAC_RST_BYTE;
         timer_mask_reg_q <= `TBAC_RST_BYTE;
         power_q          <= `TBAC_RST_POWER;
      end else begin
         if (wr && paddr == `TBAC_A_CTRLA)
            timer_ctrl_a_q <= wb; // RL8
         if (wr && paddr == `TBAC_A_CTRLB)
            timer_ctrl_b_q <= wb; // RL8
         if (wr && paddr == `TBAC_A_MASK)
            timer_mask_reg_q <= wb & `TBAC_FLAG_BITS; // RL9
         // power register stays writable while the timer is off
         if (done && pwrite && pstrb[0] && paddr == `TBAC_A_POWER)
            power_q <= {7'h00, wb[`TBAC_P_OFF]}; // RL20
      end
   end

   // counter: cpu write first, then count
   always @(posedge sys_clk) begin
      if (!resetn) begin
         count_value_q <= `TBAC_RST_WORD;
         dir_up_q      <= 1'b1;
      end else if (wr && paddr == `TBAC_A_CNT_LO) begin
         count_value_q <= {hold_hi_q, wb}; // RL1 RL3 RL21
      end else if (run) begin
         if (dual) begin
            if (dir_up_q && at_top) begin
               dir_up_q      <= 1'b0;
               count_value_q <= count_value_q - `TBAC_ONE;
            end else if (!dir_up_q && at_bot) begin
               dir_up_q      <= 1'b1;
               count_value_q <= count_value_q + `TBAC_ONE;
            end else if (dir_up_q) begin
               count_value_q <= count_value_q + `TBAC_ONE;
            end else begin
               count_value_q <= count_value_q - `TBAC_ONE;
            end
         end else if (at_top) begin
            count_value_q <= `TBAC_BOTTOM; // RL18
            dir_up_q      <= 1'b1;
         end else begin
            count_value_q <= count_value_q + `TBAC_ONE;
            dir_up_q      <= 1'b1;
         end
      end
   end

   // compare buffers; PWM modes take new values only at top
   wire upd = ~pwm | (run & at_top);
   always @(posedge sys_clk) begin
      if (!resetn) begin
         compare_a_value_q <= `TBAC_RST_WORD;
         compare_b_value_q <= `TBAC_RST_WORD;
         cmpa_eff_q        <= `TBAC_RST_WORD;
         cmpb_eff_q        <= `TBAC_RST_WORD;
      end else begin
         if (wr && paddr == `TBAC_A_CMPA_LO)
            compare_a_value_q <= {hold_hi_q, wb}; // RL3
         if (wr && paddr == `TBAC_A_CMPB_LO)
            compare_b_value_q <= {hold_hi_q, wb}; // RL3
         if (upd) begin
            cmpa_eff_q <= compare_a_value_q; // RL19
            cmpb_eff_q <= compare_b_value_q;
         end
      end
   end

   // capture register: event copy when not used as top, or cpu write in any mode
   always @(posedge sys_clk) begin
      if (!resetn)
         capture_value_q <= `TBAC_RST_WORD;
      else if (wr && paddr == `TBAC_A_CAP_LO)
         capture_value_q <= {hold_hi_q, wb}; // RL3
      else if (cap_ev)
         capture_value_q <= count_value_q; // RL14
   end

   // flags: hardware set wins over a write-one clear in the same cycle
   wire [7:0] set_v = {2'h0, cap_ev, 2'h0,
                       run & mat_b, run & mat_a, run & ovf_ev};
   wire [7:0] clr_v = (wr && paddr == `TBAC_A_FLAG) ?
                      (wb & `TBAC_FLAG_BITS) : 8'h00;
   always @(posedge sys_clk) begin
      if (!resetn)
         timer_flag_reg_q <= `TBAC_RST_BYTE;
      else
         timer_flag_reg_q <= (timer_flag_reg_q & ~clr_v) | set_v; // RL9 RL12 RL22
   end

   // waveform outputs; compare A acting as PWM top only toggles
   wire [1:0] om_a = timer_ctrl_a_q[`TBAC_CA_MODEA];
   wire [1:0] om_b = timer_ctrl_a_q[`TBAC_CA_MODEB];
   function wave_next;
      input       cur;
      input [1:0] om;
      input       mat;
      input       wrap;
      input       is_pwm;
      input       is_dual;
      input       up;
      input       no_pwm;
      reg         lvl;
      begin
         lvl = (om == `TBAC_OM_SET);
         wave_next = cur;
         if (om == `TBAC_OM_OFF)
            wave_next = 1'b0;
         else if (!is_pwm || no_pwm) begin
            if (mat && om == `TBAC_OM_TOG)
               wave_next = ~cur;
            else if (mat && !is_pwm)
               wave_next = lvl;
         end else if (is_dual) begin
            if (mat)
               wave_next = up ? lvl : ~lvl;
         end else if (mat)
            wave_next = lvl;
         else if (wrap)
            wave_next = ~lvl;
      end
   endfunction

   always @(posedge sys_clk) begin
      if (!resetn) begin
         wave_out_a <= 1'b0;
         wave_out_b <= 1'b0;
      end else if (run) begin
         wave_out_a <= wave_next(wave_out_a, om_a, mat_a, at_top, pwm,
                                 dual, dir_up_q, a_top); // RL13 RL19
         wave_out_b <= wave_next(wave_out_b, om_b, mat_b, at_top, pwm,
                                 dual, dir_up_q, 1'b0); // RL13
      end else if (om_a == `TBAC_OM_OFF || om_b == `TBAC_OM_OFF) begin
         // a disconnected output drops low even with the timer stopped
         if (om_a == `TBAC_OM_OFF)
            wave_out_a <= 1'b0;
         if (om_b == `TBAC_OM_OFF)
            wave_out_b <= 1'b0;
      end
   end

   // status outputs, one cycle behind the counter and the flag register
   always @(posedge sys_clk) begin
      if (!resetn) begin
         timer_irq       <= 1'b0;
         count_at_bottom <= 1'b1;
         count_at_max    <= 1'b0;
      end else begin
         timer_irq       <= |(timer_flag_reg_q & timer_mask_reg_q); // RL9
         count_at_bottom <= at_bot; // RL16
         count_at_max    <= (count_value_q == `TBAC_MAX); // RL17
      end
   end

endmodule // tbac_core

// ===== verif/tbac_apb_master.sv
// tbac_apb_master.sv: apb master standing in for the cpu and its software.
// assumes one clock shared with the timer; one transfer at a time.
`timescale 1ns/1ps
module tbac_apb_master (
   input  wire logic        sys_clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // bus idle at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pstrb = 4'h0;
   end

   // one byte per transfer; callers order the byte pairs
   // single master with no handler, so no pair is split
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] rd,
                       output logic err, output logic to);
      int i;
      rd = 8'h00;
      err = 1'b0;
      to = 1'b1;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      pstrb <= 4'hF;
      @(posedge sys_clk);
      penable <= 1'b1;
      // request held until pready is seen at an edge, for at most 16 edges
      for (i = 0; i < 16; i++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) begin
            rd = prdata[7:0];
            err = pslverr;
            to = 1'b0;
            break;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // tbac_apb_master

// ===== verif/tbac_core_assertions.sv
// tbac_core_assertions.sv: port-level checker for the byte-access timer.
// assumes it is bound into every tbac_core instance.
`timescale 1ns/1ps
`include "tbac_defines.vh"
module tbac_core_assertions #(
   parameter ADDR_W   = 8,
   parameter FILT_LEN = 4
) (
   input wire logic              sys_clk,
   input wire logic              resetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              timer_irq,
   input wire logic              count_at_bottom,
   input wire logic              count_at_max
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   wire wr_done = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
   wire rd_take = psel && penable && !pready && !pwrite;
   wire unmap = (paddr > 8'h30) || (paddr[1:0] != 2'b00);
   logic       pwr_q, hold_ok_q;
   logic [7:0] hold_q, mask_q;
   logic [2:0] cs_q;
   wire cnt_lo_wr = wr_done && !pwr_q && paddr == `TBAC_A_CNT_LO
                    && cs_q == `TBAC_CS_STOP && hold_ok_q;

   // shadow of power bit, clock select, mask and the shared high byte;
   // the holding byte is unknown once a low read has refilled it
   always @(posedge sys_clk) begin
      if (!resetn) begin
         pwr_q <= 1'b0;
         hold_ok_q <= 1'b0;
         hold_q <= 8'h00;
         mask_q <= 8'h00;
         cs_q <= 3'h0;
      end else begin
         if (wr_done && paddr == `TBAC_A_POWER) pwr_q <= pwdata[0];
         if (wr_done && !pwr_q && paddr == `TBAC_A_CTRLB) cs_q <= pwdata[2:0];
         if (wr_done && !pwr_q && paddr == `TBAC_A_MASK) mask_q <= pwdata[7:0];
         if (wr_done && !pwr_q && paddr[2:0] == 3'h4 && paddr >= 8'h0C
             && paddr <= 8'h24) begin
            hold_q <= pwdata[7:0];
            hold_ok_q <= 1'b1;
         end
         if (rd_take && (paddr == `TBAC_A_CNT_LO || paddr == `TBAC_A_CAP_LO))
            hold_ok_q <= 1'b0;
      end
   end

   a_ready_follows: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing one cycle after access");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_cause: assert property ($rose(pready) |-> $past(psel && penable))
      else $error("pready without a request");
   a_err_decode: assert property (pready |-> pslverr == unmap)
      else $error("pslverr does not match address decode");
   a_byte_data: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data wider than a byte");
   a_bottom_write: assert property (cnt_lo_wr && hold_q == 8'h00
      && pwdata[7:0] == 8'h00 |-> ##2 count_at_bottom && !count_at_max)
      else $error("bottom not shown after counter write of zero");
   a_max_write: assert property (cnt_lo_wr && hold_q == 8'hFF
      && pwdata[7:0] == 8'hFF |-> ##2 count_at_max && !count_at_bottom)
      else $error("max not shown after counter write of all ones");
   a_irq_masked: assert property (mask_q == 8'h00 |=> !timer_irq)
      else $error("interrupt raised with all sources masked");
endmodule // tbac_core_assertions

bind tbac_core tbac_core_assertions #(.ADDR_W(ADDR_W), .FILT_LEN(FILT_LEN))
   i_chk (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
          .penable(penable), .pwrite(pwrite), .paddr(paddr),
          .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
          .pready(pready), .pslverr(pslverr), .timer_irq(timer_irq),
          .count_at_bottom(count_at_bottom), .count_at_max(count_at_max));

// ===== verif/testbench.sv
// testbench.sv: directed register-sequence tests of the byte-access timer.
// assumes the apb master model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "tbac_defines.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("FAIL %s %h exp %h got %h", nm, cur, e, g); end end
module testbench;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        cap_pin = 1'b0;
   logic        cmp_out = 1'b0;
   logic        ext_pin = 1'b0;
   wire         psel, penable, pwrite, pready, pslverr;
   wire  [7:0]  paddr;
   wire  [31:0] pwdata, prdata;
   wire  [3:0]  pstrb;
   wire         wave_a, wave_b, irq, at_bot, at_max;
   logic [7:0]  rdat, cur;
   logic        rerr, rto;
   int          n_mismatch = 0;
   int          compares = 0;
   always #20 sys_clk = ~sys_clk;

   tbac_apb_master i_apb (.sys_clk(sys_clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   tbac_core #(.ADDR_W(8), .FILT_LEN(4)) i_dut (.sys_clk(sys_clk),
      .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .capture_input_pin(cap_pin),
      .comparator_out(cmp_out), .external_count_pin(ext_pin),
      .wave_out_a(wave_a), .wave_out_b(wave_b), .timer_irq(irq),
      .count_at_bottom(at_bot), .count_at_max(at_max));

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // a hung transfer ends the run at once
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      cur = a;
      i_apb.xfer(w, a, d, rdat, rerr, rto);
      if (rto) begin
         n_mismatch++;
         $display("FAIL pready %h exp 1 got 0", a);
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      `CHK("read", e, rdat)
   endtask
   // bounded polling; rereads are cheap
   task automatic poll(input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] e);
      int i;
      for (i = 0; i < 60; i++) begin
         acc(1'b0, a, 8'h00);
         if ((rdat & m) === e) break;
      end
      `CHK("poll", e, rdat & m)
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   initial begin
      ticks(3);
      resetn <= 1'b1;
      ticks(1);
      `CHK("bottom", 1'b1, at_bot)
      `CHK("max", 1'b0, at_max)
      rd(`TBAC_A_CTRLA, 8'h00); rd(`TBAC_A_CTRLB, 8'h00);
      rd(`TBAC_A_FLAG, 8'h00); rd(`TBAC_A_MASK, 8'h00);
      rd(`TBAC_A_POWER, 8'h00);
      wr(`TBAC_A_CTRLA, 8'hF3); rd(`TBAC_A_CTRLA, 8'hF3);
      wr(`TBAC_A_CTRLB, 8'hF8); rd(`TBAC_A_CTRLB, 8'hF8);
      wr(`TBAC_A_CTRLA, 8'h00); wr(`TBAC_A_CTRLB, 8'h00);
      $display("test control done");
      wr(`TBAC_A_CMPA_HI, 8'h5A); rd(`TBAC_A_CMPA_HI, 8'h00);
      wr(`TBAC_A_CMPA_LO, 8'h3C); rd(`TBAC_A_CMPA_LO, 8'h3C);
      rd(`TBAC_A_CMPA_HI, 8'h5A);
      wr(`TBAC_A_CNT_HI, 8'h12); wr(`TBAC_A_CNT_LO, 8'h34);
      rd(`TBAC_A_CNT_LO, 8'h34); rd(`TBAC_A_CMPA_HI, 8'h5A);
      rd(`TBAC_A_CNT_HI, 8'h12);
      wr(`TBAC_A_CNT_HI, 8'h77); wr(`TBAC_A_CMPB_LO, 8'h11);
      rd(`TBAC_A_CMPB_LO, 8'h11); rd(`TBAC_A_CMPB_HI, 8'h77);
      wr(`TBAC_A_CNT_HI, 8'h00); wr(`TBAC_A_CNT_LO, 8'h00); ticks(2);
      `CHK("bottom", 1'b1, at_bot)
      wr(`TBAC_A_CNT_HI, 8'hFF); wr(`TBAC_A_CNT_LO, 8'hFF); ticks(2);
      `CHK("max", 1'b1, at_max)
      $display("test byte access done");
      wr(`TBAC_A_POWER, 8'h01); wr(`TBAC_A_CTRLA, 8'hC0);
      rd(`TBAC_A_CTRLA, 8'h00);
      wr(`TBAC_A_POWER, 8'h00); rd(`TBAC_A_CTRLA, 8'h00);
      acc(1'b0, 8'h34, 8'h00);
      `CHK("slverr", 1'b1, rerr)
      $display("test power and decode done");
      wr(`TBAC_A_CNT_HI, 8'h12); wr(`TBAC_A_CNT_LO, 8'h34);
      wr(`TBAC_A_CTRLB, 8'h40); wr(`TBAC_A_MASK, 8'h20);
      cap_pin <= 1'b1;
      poll(`TBAC_A_FLAG, 8'h20, 8'h20);
      ticks(2);
      `CHK("irq", 1'b1, irq)
      rd(`TBAC_A_CAP_LO, 8'h34); rd(`TBAC_A_CAP_HI, 8'h12);
      wr(`TBAC_A_FLAG, 8'h00); rd(`TBAC_A_FLAG, 8'h20);
      wr(`TBAC_A_FLAG, 8'h20); rd(`TBAC_A_FLAG, 8'h00);
      ticks(2);
      `CHK("irq", 1'b0, irq)
      wr(`TBAC_A_CTRLB, 8'h60); cap_pin <= 1'b0; cmp_out <= 1'b1;
      poll(`TBAC_A_FLAG, 8'h20, 8'h20);
      wr(`TBAC_A_CTRLB, 8'hC0); wr(`TBAC_A_FLAG, 8'h20);
      cap_pin <= 1'b1; ticks(2); cap_pin <= 1'b0; ticks(10);
      rd(`TBAC_A_FLAG, 8'h00);
      cap_pin <= 1'b1;
      poll(`TBAC_A_FLAG, 8'h20, 8'h20);
      wr(`TBAC_A_MASK, 8'h00); wr(`TBAC_A_FLAG, 8'h27);
      $display("test capture done");
      wr(`TBAC_A_CNT_HI, 8'hFF); wr(`TBAC_A_CNT_LO, 8'hF0);
      wr(`TBAC_A_CTRLB, 8'h02);
      poll(`TBAC_A_FLAG, 8'h01, 8'h01);
      wr(`TBAC_A_CTRLB, 8'h00); wr(`TBAC_A_FLAG, 8'h27);
      wr(`TBAC_A_CMPA_HI, 8'h00); wr(`TBAC_A_CMPA_LO, 8'h40);
      wr(`TBAC_A_CMPB_HI, 8'h00); wr(`TBAC_A_CMPB_LO, 8'h50);
      wr(`TBAC_A_CNT_HI, 8'h00); wr(`TBAC_A_CNT_LO, 8'h00);
      wr(`TBAC_A_CTRLA, 8'h50); wr(`TBAC_A_CTRLB, 8'h01);
      poll(`TBAC_A_FLAG, 8'h06, 8'h06);
      `CHK("wave a", 1'b1, wave_a)
      `CHK("wave b", 1'b1, wave_b)
      wr(`TBAC_A_CTRLB, 8'h00); wr(`TBAC_A_CTRLA, 8'h00);
      $display("test count and compare done");
      wr(`TBAC_A_CNT_HI, 8'h00); wr(`TBAC_A_CNT_LO, 8'h00);
      wr(`TBAC_A_CTRLB, 8'h07);
      // pin half periods above one clock
      repeat (3) begin
         ext_pin <= 1'b1; ticks(3); ext_pin <= 1'b0; ticks(3);
      end
      ticks(6);
      rd(`TBAC_A_CNT_LO, 8'h03);
      wr(`TBAC_A_CTRLB, 8'h00); ticks(4);
      repeat (2) begin
         ext_pin <= 1'b1; ticks(3); ext_pin <= 1'b0; ticks(3);
      end
      rd(`TBAC_A_CNT_LO, 8'h03);
      $display("test external clock done");
      report_and_stop();
   end
endmodule // testbench
